// ### pkg/ldc_pkg.sv
// Constants shared by the display control decoder
package ldc_pkg;

   // ==========================================================
   // Instruction codes and masks (byte & mask == code)
   // ==========================================================
   localparam logic [7:0] LDC_OP_DISP_ONOFF = 8'hAE;
   localparam logic [7:0] LDC_MK_DISP_ONOFF = 8'hFE;
   localparam logic [7:0] LDC_OP_PAGE       = 8'hB0;
   localparam logic [7:0] LDC_MK_PAGE       = 8'hF0;
   localparam logic [7:0] LDC_OP_COL_HI     = 8'h10;
   localparam logic [7:0] LDC_OP_COL_LO     = 8'h00;
   localparam logic [7:0] LDC_MK_NIBBLE     = 8'hF0;
   localparam logic [7:0] LDC_OP_SEG_ORDER  = 8'hA0;
   localparam logic [7:0] LDC_OP_POLARITY   = 8'hA6;
   localparam logic [7:0] LDC_OP_ALL_ON     = 8'hA4;
   localparam logic [7:0] LDC_OP_ICON       = 8'hAA;
   localparam logic [7:0] LDC_MK_FLAG       = 8'hFE;
   localparam logic [7:0] LDC_OP_RMW        = 8'hE0;
   localparam logic [7:0] LDC_OP_END        = 8'hEE;
   localparam logic [7:0] LDC_OP_SOFT_RST   = 8'hE2;
   localparam logic [7:0] LDC_OP_SCAN       = 8'hC0;
   localparam logic [7:0] LDC_OP_SUPPLY     = 8'h24;
   localparam logic [7:0] LDC_OP_DRIVE_SET  = 8'hED;
   localparam logic [7:0] LDC_OP_CONTRAST   = 8'h80;
   localparam logic [7:0] LDC_MK_EXACT      = 8'hFF;

   // ==========================================================
   // Field positions and limits
   // ==========================================================
   localparam int         LDC_FLAG_BIT      = 0;
   localparam int         LDC_SCAN_BIT      = 3;
   localparam int         LDC_BYTE_BITS     = 8;
   localparam logic [7:0] LDC_COL_LAST      = 8'hA0;
   localparam logic [2:0] LDC_PAGE_LAST     = 3'h4;
   localparam logic [2:0] LDC_BIT_COUNT_TOP = 3'h7;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] LDC_COL_RST       = 8'h00;
   localparam logic [2:0] LDC_PAGE_RST      = 3'h0;
   localparam logic [3:0] LDC_CONTRAST_RST  = 4'h0;

   // Decoder sequencing: capture a byte, then execute it
   typedef enum logic [1:0] {
      LDC_ST_IDLE = 2'b01,
      LDC_ST_EXEC = 2'b10
   } ldc_state_t;

endpackage : ldc_pkg

// ### hdl/ldc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module ldc_pin_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         i_clock,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync2_reg;
   logic [W-1:0] sync3_reg;

   // ==========================================================
   // Chain: first stage feeds only the second
   // ==========================================================
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta_reg  <= RST_VAL;
         sync2_reg <= RST_VAL;
         sync3_reg <= RST_VAL;
      end else begin
         meta_reg  <= i_pin;
         sync2_reg <= meta_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // A bit moves only once the last two stages agree, filtering one-cycle glitches
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_level <= RST_VAL;
      end else begin
         o_level <= (sync3_reg & ~(sync2_reg ^ sync3_reg)) | (o_level & (sync2_reg ^ sync3_reg));
      end
   end

endmodule : ldc_pin_sync

// ### hdl/ldc_decoder.sv
// Display control and power control instruction decoder with state
//
// Operation
// - Polarity flag 0 lights stored ones, flag 1 lights stored zeros; RAM untouched.
// - All-pixels flag 1 lights every pixel, flag 0 returns to RAM display.
// - All-pixels-lit overrides the polarity setting when deriving pixels.
// - All-pixels flag 1 while display is off enters power save.
// - Icon flag selects 1/32 or 1/33 duty; first common shows page 4 bit D0.
// - In read-modify-write, writes advance column by one, reads leave it unchanged.
// - End leaves read-modify-write and restores the column held at entry.
// - Soft reset zeroes column, page, scan order bit and contrast step.
// - Scan order instruction stores D3 only, ignoring D2 to D0.
// - Supply flag enables or disables booster, regulator and follower together.
// - Booster runs only while the oscillator runs.
// - Outputs sit at positive supply until drive-voltage-set executes.
// - Contrast instruction loads its low four bits, sixteen levels.
// - Power save starts when both display-off and all-pixels-lit are in effect.
// - Power save stops oscillator and supply, outputs at supply, keeps state.
// - All-pixels flag 0 ends power save; display-on may follow any time.
// - Serial byte is instruction if select is low at eighth clock edge.
// - End is byte 0xEE with command/data select low.
`timescale 1ns/100ps

module ldc_decoder
   import ldc_pkg::*;
(
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       i_ser_clock,
   input  wire logic       i_ser_data,
   input  wire logic       i_ser_select_n,
   input  wire logic       i_command_data_select,
   input  wire logic       i_par_valid,
   input  wire logic [7:0] i_par_byte,
   input  wire logic       i_par_cmd_data_select,
   input  wire logic       i_par_read,
   input  wire logic       i_ram_bit,
   output logic            o_busy,
   output logic            o_pixel_lit,
   output logic            o_display_on,
   output logic            o_inverse,
   output logic            o_all_on,
   output logic            o_seg_reverse,
   output logic            o_icon_duty,
   output logic            o_rmw_mode,
   output logic [7:0]      o_column_addr,
   output logic [2:0]      o_page_addr,
   output logic            o_scan_order_bit,
   output logic [3:0]      o_contrast_step,
   output logic            o_supply_enable,
   output logic            o_osc_enable,
   output logic            o_hold_at_supply,
   output logic            o_power_save,
   output logic            o_ram_write,
   output logic [7:0]      o_ram_wdata
);

   // ==========================================================
   // Pin synchronisers and serial shifter
   // ==========================================================
   logic [3:0]  pins_level;
   logic        scl_prev_reg;
   logic [2:0]  bit_count_reg;
   logic [7:0]  shift_reg;
   logic        ser_done;
   logic        scl_rise;

   ldc_pin_sync #(.W(4), .RST_VAL(4'h8)) u_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_pin   ({i_ser_select_n, i_command_data_select, i_ser_data, i_ser_clock}),
      .o_level (pins_level)
   );

   assign scl_rise = pins_level[0] & ~scl_prev_reg;
   assign ser_done = scl_rise & ~pins_level[3] & (bit_count_reg == LDC_BIT_COUNT_TOP);

   // Shift MSB first; deselect clears the counter so a partial byte is dropped
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         scl_prev_reg  <= 1'b0;
         bit_count_reg <= '0;
         shift_reg     <= '0;
      end else begin
         scl_prev_reg <= pins_level[0];
         if (pins_level[3]) begin
            bit_count_reg <= '0;
         end else if (scl_rise) begin
            bit_count_reg <= bit_count_reg + 3'h1;
            shift_reg     <= {shift_reg[6:0], pins_level[1]};
         end
      end
   end

   // ==========================================================
   // Capture and execute sequencing
   // ==========================================================
   ldc_state_t  state_reg;
   logic [7:0]  cmd_reg;
   logic        is_data_reg;
   logic        is_read_reg;
   logic        exec;

   assign exec = (state_reg == LDC_ST_EXEC) & ~is_data_reg;

   // Serial wins over parallel; host keeps one or the other idle
   // Capture, then execute next cycle
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_reg   <= LDC_ST_IDLE;
         cmd_reg     <= '0;
         is_data_reg <= 1'b0;
         is_read_reg <= 1'b0;
         o_busy      <= 1'b0;
      end else begin
         case (state_reg)
            LDC_ST_IDLE: begin
               if (ser_done) begin
                  cmd_reg     <= {shift_reg[6:0], pins_level[1]};
                  is_data_reg <= pins_level[2];
                  is_read_reg <= 1'b0;
                  state_reg   <= LDC_ST_EXEC;
                  o_busy      <= 1'b1;
               end else if (i_par_valid) begin
                  cmd_reg     <= i_par_byte;
                  is_data_reg <= i_par_cmd_data_select;
                  is_read_reg <= i_par_read & i_par_cmd_data_select;
                  state_reg   <= LDC_ST_EXEC;
                  o_busy      <= 1'b1;
               end
            end
            // Busy is a register copy of the execute state, so the pin is glitch free
            LDC_ST_EXEC: begin
               state_reg <= LDC_ST_IDLE;
               o_busy    <= 1'b0;
            end
            default: begin
               state_reg <= LDC_ST_IDLE;
               o_busy    <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Instruction decode (undefined bytes match nothing)
   // ==========================================================
   // Unmatched bytes raise no strobe
   function automatic logic hit(input logic [7:0] b, input logic [7:0] code, input logic [7:0] mask);
      hit = ((b & mask) == code);
   endfunction : hit

   logic flag;
   logic dec_disp, dec_page, dec_col_hi, dec_col_lo, dec_seg, dec_pol, dec_all;
   logic dec_icon, dec_rmw, dec_end, dec_srst, dec_scan, dec_supply, dec_drive, dec_contrast;

   assign flag         = cmd_reg[LDC_FLAG_BIT];
   assign dec_disp     = exec & hit(cmd_reg, LDC_OP_DISP_ONOFF, LDC_MK_DISP_ONOFF);
   assign dec_page     = exec & hit(cmd_reg, LDC_OP_PAGE, LDC_MK_PAGE) & (cmd_reg[2:0] <= LDC_PAGE_LAST);
   assign dec_col_hi   = exec & hit(cmd_reg, LDC_OP_COL_HI, LDC_MK_NIBBLE);
   assign dec_col_lo   = exec & hit(cmd_reg, LDC_OP_COL_LO, LDC_MK_NIBBLE);
   assign dec_seg      = exec & hit(cmd_reg, LDC_OP_SEG_ORDER, LDC_MK_FLAG);
   assign dec_pol      = exec & hit(cmd_reg, LDC_OP_POLARITY, LDC_MK_FLAG);
   assign dec_all      = exec & hit(cmd_reg, LDC_OP_ALL_ON, LDC_MK_FLAG);
   assign dec_icon     = exec & hit(cmd_reg, LDC_OP_ICON, LDC_MK_FLAG);
   assign dec_rmw      = exec & hit(cmd_reg, LDC_OP_RMW, LDC_MK_EXACT);
   // End decoded only as an instruction
   assign dec_end      = exec & hit(cmd_reg, LDC_OP_END, LDC_MK_EXACT);
   assign dec_srst     = exec & hit(cmd_reg, LDC_OP_SOFT_RST, LDC_MK_EXACT);
   assign dec_scan     = exec & hit(cmd_reg, LDC_OP_SCAN, LDC_MK_NIBBLE);
   assign dec_supply   = exec & hit(cmd_reg, LDC_OP_SUPPLY, LDC_MK_FLAG);
   assign dec_drive    = exec & hit(cmd_reg, LDC_OP_DRIVE_SET, LDC_MK_EXACT);
   assign dec_contrast = exec & hit(cmd_reg, LDC_OP_CONTRAST, LDC_MK_NIBBLE);

   // ==========================================================
   // Display mode flags
   // ==========================================================
   // Polarity and all-on latched from flag
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_display_on  <= 1'b0;
         o_inverse     <= 1'b0;
         o_all_on      <= 1'b0;
         o_seg_reverse <= 1'b0;
         o_icon_duty   <= 1'b0;
      end else begin
         if (dec_disp) begin
            o_display_on <= flag;
         end
         if (dec_pol) begin
            o_inverse <= flag;
         end
         if (dec_all) begin
            o_all_on <= flag;
         end
         if (dec_seg) begin
            o_seg_reverse <= flag;
         end
         if (dec_icon) begin
            o_icon_duty <= flag;
         end
      end
   end

   // All-on beats polarity; RAM bit never written here
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pixel_lit <= 1'b0;
      end else begin
         o_pixel_lit <= o_all_on | (i_ram_bit ^ o_inverse);
      end
   end

   // ==========================================================
   // Column, page, read-modify-write
   // ==========================================================
   logic [7:0] col_saved_reg;
   logic       col_step;

   // Reads only step outside read-modify-write; stop at last column
   assign col_step = (state_reg == LDC_ST_EXEC) & is_data_reg & ~(is_read_reg & o_rmw_mode)
                     & (o_column_addr != LDC_COL_LAST);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_column_addr <= LDC_COL_RST;
         col_saved_reg <= LDC_COL_RST;
         o_rmw_mode    <= 1'b0;
      end else begin
         if (dec_rmw) begin
            o_rmw_mode    <= 1'b1;
            col_saved_reg <= o_column_addr;
         end else if (dec_end) begin
            // Leave mode and restore entry column
            o_rmw_mode    <= 1'b0;
            o_column_addr <= col_saved_reg;
         end else if (dec_srst) begin
            o_column_addr <= LDC_COL_RST;
         end else if (dec_col_hi) begin
            // Host keeps these out of read-modify-write
            o_column_addr <= {cmd_reg[3:0], o_column_addr[3:0]};
         end else if (dec_col_lo) begin
            o_column_addr <= {o_column_addr[7:4], cmd_reg[3:0]};
         end else if (col_step) begin
            o_column_addr <= o_column_addr + 8'h01;
         end
      end
   end

   // Page returns to zero on soft reset
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_page_addr <= LDC_PAGE_RST;
      end else if (dec_srst) begin
         o_page_addr <= LDC_PAGE_RST;
      end else if (dec_page) begin
         o_page_addr <= cmd_reg[2:0];
      end
   end

   // Display data writes pass straight to the RAM port
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_ram_write <= 1'b0;
         o_ram_wdata <= '0;
      end else begin
         o_ram_write <= (state_reg == LDC_ST_EXEC) & is_data_reg & ~is_read_reg;
         o_ram_wdata <= cmd_reg;
      end
   end

   // ==========================================================
   // Scan order and contrast step
   // ==========================================================
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_scan_order_bit <= 1'b0;
         o_contrast_step  <= LDC_CONTRAST_RST;
      end else if (dec_srst) begin
         o_scan_order_bit <= 1'b0;
         o_contrast_step  <= LDC_CONTRAST_RST;
      end else begin
         if (dec_scan) begin
            o_scan_order_bit <= cmd_reg[LDC_SCAN_BIT];
         end
         if (dec_contrast) begin
            o_contrast_step <= cmd_reg[3:0];
         end
      end
   end

   // ==========================================================
   // Power: supply, drive enable, power save
   // ==========================================================
   logic supply_on_reg;
   logic drive_set_reg;
   logic ps_next;

   // Save is display-off with all-on; set by second command
   assign ps_next = ~(dec_disp ? flag : o_display_on) & (dec_all ? flag : o_all_on);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         supply_on_reg <= 1'b0;
         drive_set_reg <= 1'b0;
         o_power_save  <= 1'b0;
      end else begin
         // One flag for booster, regulator, follower
         if (dec_supply) begin
            supply_on_reg <= flag;
         end
         if (dec_drive) begin
            drive_set_reg <= 1'b1;
         end
         o_power_save <= ps_next;
      end
   end

   // Save stops oscillator, supply follows oscillator
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_osc_enable     <= 1'b1;
         o_supply_enable  <= 1'b0;
         o_hold_at_supply <= 1'b1;
      end else begin
         o_osc_enable     <= ~ps_next;
         o_supply_enable  <= (dec_supply ? flag : supply_on_reg) & ~ps_next;
         o_hold_at_supply <= ~(drive_set_reg | dec_drive) | ps_next;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_all_on_cmd;
      dec_all & flag & ~o_display_on;
   endsequence

   sequence s_rmw_enter;
      dec_rmw;
   endsequence

   polarity_apply_a: assert property (dec_pol |=> o_inverse == $past(flag))
      else $error("polarity flag not stored");
   all_on_pixel_a: assert property (o_all_on |=> o_pixel_lit)
      else $error("all-on did not light pixel");
   pixel_polarity_a: assert property (!o_all_on |=> o_pixel_lit == ($past(i_ram_bit) ^ $past(o_inverse)))
      else $error("pixel polarity wrong");
   save_entry_a: assert property (s_all_on_cmd |=> o_power_save ##1 !o_osc_enable)
      else $error("power save not entered");
   save_outputs_a: assert property (o_power_save |-> o_hold_at_supply && !o_supply_enable)
      else $error("outputs active in power save");
   save_release_a: assert property (dec_all && !flag |=> !o_power_save)
      else $error("power save not released");
   rmw_save_a: assert property (s_rmw_enter |=> col_saved_reg == $past(o_column_addr))
      else $error("entry column not saved");
   rmw_restore_a: assert property (dec_end |=> o_column_addr == $past(col_saved_reg) && !o_rmw_mode)
      else $error("column not restored at end");
   rmw_read_hold_a: assert property (o_rmw_mode && (state_reg == LDC_ST_EXEC) && is_read_reg
                                     |=> $stable(o_column_addr))
      else $error("column moved on read");
   soft_reset_a: assert property (dec_srst |=> o_column_addr == LDC_COL_RST && o_page_addr == LDC_PAGE_RST
                                  && !o_scan_order_bit && o_contrast_step == LDC_CONTRAST_RST)
      else $error("soft reset incomplete");
   drive_hold_a: assert property (!drive_set_reg && !dec_drive |=> o_hold_at_supply)
      else $error("outputs released before drive set");
   booster_osc_a: assert property (o_supply_enable |-> o_osc_enable)
      else $error("booster without oscillator");
   one_cycle_exec_a: assert property (state_reg == LDC_ST_EXEC |=> state_reg == LDC_ST_IDLE)
      else $error("execute longer than one cycle");

endmodule : ldc_decoder

// ### verif/ldc_host_model.sv
// Host side model: sends instruction and data bytes on the parallel and serial ports
`timescale 1ns/100ps

module ldc_host_model (
   input  wire logic       i_clock,
   output logic            o_par_valid,
   output logic [7:0]      o_par_byte,
   output logic            o_par_sel,
   output logic            o_par_read,
   output logic            o_ser_clock,
   output logic            o_ser_data,
   output logic            o_ser_select_n,
   output logic            o_cds
);
   // ==========================================================
   // Idle levels
   // ==========================================================
   // Serial clock rests low outside frames, select deasserted
   initial begin
      o_par_valid    = 1'b0;
      o_par_byte     = 8'h00;
      o_par_sel      = 1'b0;
      o_par_read     = 1'b0;
      o_ser_clock    = 1'b0;
      o_ser_data     = 1'b0;
      o_ser_select_n = 1'b1;
      o_cds          = 1'b0;
   end

   // ==========================================================
   // Byte transfers
   // ==========================================================
   // wait out busy
   // Idle cycles after each byte keep the next one clear of the execute cycle
   task automatic par_send(input logic [7:0] b, input logic sel, input logic rd);
      o_par_byte  <= b;
      o_par_sel   <= sel;
      o_par_read  <= rd;
      o_par_valid <= 1'b1;
      @(posedge i_clock);
      o_par_valid <= 1'b0;
      o_par_byte  <= ~b;           // Released bus does not keep the old value
      repeat (3) @(posedge i_clock);
   endtask : par_send

   // whole serial bytes
   // Phases of six cycles outlast the pin filter latency
   task automatic ser_send(input logic [7:0] b, input logic sel);
      o_ser_select_n <= 1'b0;
      o_cds          <= sel;
      for (int k = 7; k >= 0; k--) begin
         o_ser_data <= b[k];
         repeat (6) @(posedge i_clock);
         o_ser_clock <= 1'b1;
         repeat (6) @(posedge i_clock);
         o_ser_clock <= 1'b0;
      end
      repeat (6) @(posedge i_clock);
      o_ser_select_n <= 1'b1;
      o_ser_data     <= ~b[0];
      o_cds          <= ~sel;
      repeat (6) @(posedge i_clock);
   endtask : ser_send
endmodule : ldc_host_model

// ### verif/tb_top.sv
// Self-checking testbench for the display control decoder
`timescale 1ns/100ps

module tb_top;
   logic i_clock, i_rst, ram_bit, pv, psel, prd, sclk, sdat, ssel_n, cds;
   logic busy, pix, don, inv, allon, segr, icon, rmw, scan, sup, osc, hold, ps, rw;
   logic [7:0] pbyte, col, wdata;
   logic [2:0] page;
   logic [3:0] contrast_step_register;
   int miscompares = 0;
   int checks_done = 0;
   int wr_seen = 0;
   int busy_seen = 0;
   logic [7:0] wr_last = 8'h00;

   // ==========================================================
   // Design and host
   // ==========================================================
   ldc_host_model i_ldc_host_model (.i_clock(i_clock), .o_par_valid(pv), .o_par_byte(pbyte), .o_par_sel(psel),
      .o_par_read(prd), .o_ser_clock(sclk), .o_ser_data(sdat), .o_ser_select_n(ssel_n), .o_cds(cds));
   ldc_decoder i_ldc_decoder (.i_clock(i_clock), .i_rst(i_rst), .i_ser_clock(sclk), .i_ser_data(sdat),
      .i_ser_select_n(ssel_n), .i_command_data_select(cds), .i_par_valid(pv), .i_par_byte(pbyte),
      .i_par_cmd_data_select(psel), .i_par_read(prd), .i_ram_bit(ram_bit), .o_busy(busy), .o_pixel_lit(pix),
      .o_display_on(don), .o_inverse(inv), .o_all_on(allon), .o_seg_reverse(segr), .o_icon_duty(icon),
      .o_rmw_mode(rmw), .o_column_addr(col), .o_page_addr(page), .o_scan_order_bit(scan),
      .o_contrast_step(contrast_step_register), .o_supply_enable(sup), .o_osc_enable(osc), .o_hold_at_supply(hold),
      .o_power_save(ps), .o_ram_write(rw), .o_ram_wdata(wdata));

   // ==========================================================
   // Clock and helpers
   // ==========================================================
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // One-cycle outputs are counted at the falling edge, while they stand
   always @(negedge i_clock) begin
      if (rw === 1'b1) begin
         wr_seen++;
         wr_last = wdata;
      end
      if (busy === 1'b1) begin
         busy_seen++;
      end
   end

   // Compare one result; widths are zero extended to a byte
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Issue a byte from a rising edge, then sample at the next falling edge
   task automatic cmd(input logic [7:0] b, input logic sel = 1'b0, input logic rd = 1'b0);
      @(posedge i_clock);
      i_ldc_host_model.par_send(b, sel, rd);
      @(negedge i_clock);
   endtask : cmd

   task automatic ser(input logic [7:0] b, input logic sel);
      @(posedge i_clock);
      i_ldc_host_model.ser_send(b, sel);
      @(negedge i_clock);
   endtask : ser

   // Pixel path settles one cycle after the RAM bit
   task automatic ram(input logic v);
      @(posedge i_clock);
      ram_bit <= v;
      repeat (2) @(negedge i_clock);
   endtask : ram

   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // Watchdog: a hung run counts as a mismatch
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end

   // ==========================================================
   // Test sequence
   // ==========================================================
   initial begin
      i_rst   = 1'b1;
      ram_bit = 1'b1;
      repeat (5) @(posedge i_clock);
      i_rst <= 1'b0;
      @(negedge i_clock);
      chk("hold", 8'h01, hold);
      chk("osc", 8'h01, osc);
      chk("psave", 8'h00, ps);
      $display("test reset done");
      // supply on only with no external supply
      cmd(8'h25); chk("supply", 8'h01, sup);
      chk("busy", 8'h01, 8'(busy_seen));
      cmd(8'hED); chk("hold", 8'h00, hold);
      cmd(8'hA7); chk("inv", 8'h01, inv);
      chk("pix", 8'h00, pix);
      ram(1'b0); chk("pix", 8'h01, pix);
      ram(1'b1);
      cmd(8'hA5); chk("psave", 8'h01, ps);
      chk("allon", 8'h01, allon);
      chk("pix", 8'h01, pix);
      chk("osc", 8'h00, osc);
      chk("supply", 8'h00, sup);
      chk("hold", 8'h01, hold);
      cmd(8'hA4); chk("psave", 8'h00, ps);
      chk("osc", 8'h01, osc);
      chk("pix", 8'h00, pix);
      chk("inv", 8'h01, inv);
      cmd(8'hAF); chk("don", 8'h01, don);
      cmd(8'hA5); chk("psave", 8'h00, ps);
      chk("pix", 8'h01, pix);
      cmd(8'hAE); chk("psave", 8'h01, ps);
      chk("don", 8'h00, don);
      cmd(8'hA4); cmd(8'h24); chk("supply", 8'h00, sup);
      $display("test polarity and power done");
      cmd(8'hAB); chk("icon", 8'h01, icon);
      cmd(8'hAA); chk("icon", 8'h00, icon);
      cmd(8'hAB);
      cmd(8'hA1); chk("segr", 8'h01, segr);
      cmd(8'hC7); chk("scan", 8'h00, scan);
      cmd(8'hC8); chk("scan", 8'h01, scan);
      cmd(8'h8F); chk("evr", 8'h0F, contrast_step_register);
      cmd(8'hB3); cmd(8'hFF); cmd(8'hB5);
      chk("page", 8'h03, page);
      chk("evr", 8'h0F, contrast_step_register);
      $display("test modes done");
      cmd(8'h12); cmd(8'h05); chk("col", 8'h25, col);
      cmd(8'hE0); chk("rmw", 8'h01, rmw);
      cmd(8'h5A, 1'b1, 1'b0); chk("col", 8'h26, col);
      chk("wdata", 8'h5A, wr_last);
      chk("writes", 8'h01, 8'(wr_seen));
      cmd(8'h00, 1'b1, 1'b1); chk("col", 8'h26, col);
      chk("writes", 8'h01, 8'(wr_seen));
      cmd(8'hEE); chk("col", 8'h25, col);
      chk("rmw", 8'h00, rmw);
      $display("test rmw done");
      cmd(8'hE2);
      chk("col", 8'h00, col);
      chk("page", 8'h00, page);
      chk("scan", 8'h00, scan);
      chk("evr", 8'h00, contrast_step_register);
      chk("icon", 8'h01, icon);
      $display("test soft reset done");
      ser(8'hA6, 1'b0); chk("inv", 8'h00, inv);
      ser(8'hA7, 1'b1); chk("inv", 8'h00, inv);
      chk("col", 8'h01, col);
      chk("wdata", 8'hA7, wr_last);
      chk("writes", 8'h02, 8'(wr_seen));
      $display("test serial done");
      print_verdict();
   end
endmodule : tb_top
